// ---- tb.sv ----
// Self-checking testbench of the twelve channel modulator
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_cfg.svh"
`define TB_CHK(got, want) begin \
	samples_checked++; \
	if ((got) !== (want)) begin \
		n_errors++; \
		$display("[ERR] %0t got %h want %h", $time, got, want); \
	end \
end
module tb;
	import tcpwm_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	tcpwm_sfr_s sfr = '0;
	logic low_power = 1'b0;
	logic [3:0] port_one_latch = 4'hf;
	logic [7:0] sfr_rdata;
	logic [11:0] pin_out;
	logic [11:0] pin_oe;
	logic [7:0] counter_value;
	logic [11:0] pin_level;
	int n_errors = 0;
	int samples_checked = 0;
	bit chk_on = 1'b0;
	logic [7:0] cnt_m;
	logic [11:0] en_m;
	logic [7:0] duty_m [12];
	logic mod_m;
	logic [11:0] oe_m;
	logic [7:0] rd_m;
	logic [7:0] dadr [12] = '{`TCPWM_ADR_D0, `TCPWM_ADR_D1, `TCPWM_ADR_D2,
		`TCPWM_ADR_D3, `TCPWM_ADR_D4, `TCPWM_ADR_D5, `TCPWM_ADR_D6,
		`TCPWM_ADR_D7, `TCPWM_ADR_D8, `TCPWM_ADR_D9, `TCPWM_ADR_D10,
		`TCPWM_ADR_D11};

	always #12.5 sys_clk = ~sys_clk;

	tcpwm_top DUT (
		.sys_clk(sys_clk),
		.rst(rst),
		.sfr(sfr),
		.low_power(low_power),
		.port_one_latch(port_one_latch),
		.sfr_rdata(sfr_rdata),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.counter_value(counter_value)
	);

	tcpwm_load loads (
		.sys_clk(sys_clk),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pin_level(pin_level)
	);

	// ----------------------------------------
	// Reference model and per-cycle compare
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			cnt_m <= 8'h00;
			en_m <= 12'h000;
			mod_m <= 1'b0;
			oe_m <= 12'h000;
			rd_m <= 8'h00;
			for (int i = 0; i < 12; i++) duty_m[i] <= 8'h00;
		end else begin
			for (int i = 0; i < 12; i++) oe_m[i] <= (en_m[i] && !low_power) ?
				(duty_m[i] > cnt_m) : ((i >= 8) && !port_one_latch[i % 4]);
			if (!low_power) cnt_m <= (cnt_m >= (mod_m ? `TCPWM_TOP_254 :
				`TCPWM_TOP_256)) ? 8'h00 : cnt_m + 8'h01;
			if (sfr.wr) begin
				if (sfr.addr == `TCPWM_ADR_ENL) en_m[7:0] <= sfr.wdata;
				if (sfr.addr == `TCPWM_ADR_ENH) en_m[11:8] <= sfr.wdata[3:0];
				if (sfr.addr == `TCPWM_ADR_CTL) mod_m <= sfr.wdata[0];
				for (int k = 0; k < 12; k++)
					if (sfr.addr == dadr[k]) duty_m[k] <= sfr.wdata;
			end
			if (sfr.rd) rd_m <= (sfr.addr == `TCPWM_ADR_ENL) ? en_m[7:0] :
				(sfr.addr == `TCPWM_ADR_ENH) ? {4'h0, en_m[11:8]} : 8'h00;
		end
	end

	always @(negedge sys_clk) begin
		if (chk_on) begin
			`TB_CHK(counter_value, cnt_m)
			`TB_CHK(pin_oe, oe_m)
			`TB_CHK(sfr_rdata, rd_m)
			`TB_CHK(pin_out, 12'h000)
			`TB_CHK(pin_level[11:8], ~oe_m[11:8])
			`TB_CHK(pin_level[7:0] & oe_m[7:0], 8'h00)
		end
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge sys_clk);
		sfr.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
		@(posedge sys_clk);
		sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge sys_clk);
		sfr.rd <= 1'b0;
		@(negedge sys_clk);
		`TB_CHK(sfr_rdata, want)
	endtask

	task automatic run(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_regs;
		for (int k = 0; k < 12; k++) rd_chk(dadr[k], 8'h00);
		rd_chk(`TCPWM_ADR_CTL, 8'h00);
		rd_chk(`TCPWM_ADR_ENL, 8'h00);
		rd_chk(`TCPWM_ADR_ENH, 8'h00);
		rd_chk(8'h90, 8'h00);
		`TB_CHK(pin_oe, 12'h000)
	endtask

	task automatic t_all_channels;
		int n;
		n = 0;
		wr_reg(`TCPWM_ADR_ENL, 8'hff);
		wr_reg(`TCPWM_ADR_ENH, 8'hff);
		rd_chk(`TCPWM_ADR_ENL, 8'hff);
		rd_chk(`TCPWM_ADR_ENH, 8'h0f);
		for (int k = 0; k < 11; k++) wr_reg(dadr[k], 8'(k * 25));
		wr_reg(dadr[11], 8'hff);
		run(520);
		repeat (256) begin
			@(negedge sys_clk);
			n += int'(pin_oe[11] === 1'b1);
		end
		`TB_CHK(n, 255)
	endtask

	task automatic t_immediate;
		for (int k = 0; k < 4; k++) begin
			wr_reg(dadr[0], k[0] ? 8'hff : 8'h00);
			@(posedge sys_clk);
			@(negedge sys_clk);
			`TB_CHK(pin_oe[0], k[0] ? cnt_m != 8'h00 : 1'b0)
		end
	endtask

	task automatic t_mod254;
		int n;
		n = 0;
		wr_reg(`TCPWM_ADR_CTL, 8'h01);
		wr_reg(dadr[0], 8'hfe);
		wr_reg(dadr[1], 8'hff);
		run(4);
		repeat (508) begin
			@(negedge sys_clk);
			n += int'(pin_oe[0] !== 1'b1) + int'(pin_oe[1] !== 1'b1);
		end
		`TB_CHK(n, 0)
		wr_reg(`TCPWM_ADR_CTL, 8'h00);
	endtask

	task automatic t_low_power;
		@(posedge sys_clk);
		port_one_latch <= 4'h5;
		low_power <= 1'b1;
		wr_reg(dadr[2], 8'h10);
		run(40);
		@(negedge sys_clk);
		`TB_CHK(pin_oe, 12'ha00)
		@(posedge sys_clk);
		low_power <= 1'b0;
		wr_reg(`TCPWM_ADR_ENH, 8'h00);
		run(300);
		@(negedge sys_clk);
		`TB_CHK(pin_oe[11:8], 4'ha)
		@(posedge sys_clk);
		port_one_latch <= 4'hf;
	endtask

	task automatic t_mid_reset;
		@(posedge sys_clk);
		rst <= 1'b1;
		run(2);
		rst <= 1'b0;
		rd_chk(`TCPWM_ADR_ENL, 8'h00);
	endtask

	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		chk_on <= 1'b1;
		t_reset_regs;
		t_all_channels;
		t_immediate;
		t_mod254;
		t_low_power;
		t_mid_reset;
		complete_run;
	end

	// Whole run needs about 1750 cycles
	initial begin
		#200000;
		n_errors++;
		complete_run;
	end
endmodule // tb
`default_nettype wire

// ---- tcpwm_cfg.svh ----
// Register map, field positions and counts of the twelve channel modulator
`ifndef TCPWM_CFG_SVH
`define TCPWM_CFG_SVH

`define TCPWM_NCH 12
`define TCPWM_NLOW 8
`define TCPWM_NHIGH 4

`define TCPWM_ADR_ENH 8'hd7
`define TCPWM_ADR_CTL 8'hdf
`define TCPWM_ADR_ENL 8'he7
`define TCPWM_ADR_D0 8'hec
`define TCPWM_ADR_D1 8'hed
`define TCPWM_ADR_D2 8'hee
`define TCPWM_ADR_D3 8'hef
`define TCPWM_ADR_D4 8'hf4
`define TCPWM_ADR_D5 8'hf5
`define TCPWM_ADR_D6 8'hf6
`define TCPWM_ADR_D7 8'hf7
`define TCPWM_ADR_D8 8'hfc
`define TCPWM_ADR_D9 8'hfd
`define TCPWM_ADR_D10 8'hfe
`define TCPWM_ADR_D11 8'hff

`define TCPWM_MODSEL_BIT 0
`define TCPWM_RST_REG 8'h00
`define TCPWM_TOP_256 8'hff
`define TCPWM_TOP_254 8'hfd
`define TCPWM_UNREACH_254 8'hfe

`endif

// ---- tcpwm_chan.sv ----
// One modulator channel: compare and open-drain pin drive
`timescale 1ns/1ps
`default_nettype none
module tcpwm_chan #(
	parameter bit PORT_PIN = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] count,
	input wire logic [7:0] duty,
	input wire logic enable,
	input wire logic freeze,
	input wire logic latch_bit,
	output logic pin_oe
);
	logic oe_q;
	logic oe_d;
	logic pull_low;
	logic idle_oe;

	// Compare against the live duty value, no shadow copy
	assign pull_low = duty > count;
	// Port pins fall back to the latch, a zero pulls low
	assign idle_oe = PORT_PIN ? !latch_bit : 1'b0;
	assign oe_d = (enable && !freeze) ? pull_low : idle_oe;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= oe_d;
		end
	end

	assign pin_oe = oe_q;
endmodule // tcpwm_chan
`default_nettype wire

// ---- tcpwm_counter.sv ----
// Shared free-running period counter of the modulator
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_cfg.svh"
module tcpwm_counter (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic freeze,
	input wire logic modulo_select,
	output logic [7:0] count
);
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic [7:0] top;

	assign top = modulo_select ? `TCPWM_TOP_254 : `TCPWM_TOP_256;
	// A count left above the top by a mode change wraps at once
	assign count_d = (count_q >= top) ? 8'h00 : count_q + 8'h01;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_q <= 8'h00;
		end else if (!freeze) begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
endmodule // tcpwm_counter
`default_nettype wire

// ---- tcpwm_load.sv ----
// External loads on the open-drain modulator pins
`timescale 1ns/1ps
`default_nettype none
module tcpwm_load (
	input wire logic sys_clk,
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe,
	output logic [11:0] pin_level
);
	logic flip_q = 1'b0;

	// A floating line must not keep its last value, so it toggles
	always_ff @(posedge sys_clk) begin
		flip_q <= ~flip_q;
	end

	// Channels 8 to 11 have pull-ups, channels 0 to 7 float
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & {4'hf, {8{flip_q}}});
endmodule // tcpwm_load
`default_nettype wire

// ---- tcpwm_pkg.sv ----
// Types and the duty register decoder shared by the modulator files
`default_nettype none
`include "tcpwm_cfg.svh"
package tcpwm_pkg;
	typedef logic [7:0] tcpwm_byte_t;

	typedef struct packed {
		tcpwm_byte_t addr;
		logic wr;
		logic rd;
		tcpwm_byte_t wdata;
	} tcpwm_sfr_s;

	typedef struct packed {
		logic valid;
		logic [3:0] idx;
	} tcpwm_sel_s;

	// Duty registers sit in three scattered groups of the map
	function automatic tcpwm_sel_s tcpwm_duty_sel(tcpwm_byte_t a);
		tcpwm_sel_s s;
		s = '{valid: 1'b0, idx: 4'h0};
		case (a)
			`TCPWM_ADR_D0: s = '{valid: 1'b1, idx: 4'h0};
			`TCPWM_ADR_D1: s = '{valid: 1'b1, idx: 4'h1};
			`TCPWM_ADR_D2: s = '{valid: 1'b1, idx: 4'h2};
			`TCPWM_ADR_D3: s = '{valid: 1'b1, idx: 4'h3};
			`TCPWM_ADR_D4: s = '{valid: 1'b1, idx: 4'h4};
			`TCPWM_ADR_D5: s = '{valid: 1'b1, idx: 4'h5};
			`TCPWM_ADR_D6: s = '{valid: 1'b1, idx: 4'h6};
			`TCPWM_ADR_D7: s = '{valid: 1'b1, idx: 4'h7};
			`TCPWM_ADR_D8: s = '{valid: 1'b1, idx: 4'h8};
			`TCPWM_ADR_D9: s = '{valid: 1'b1, idx: 4'h9};
			`TCPWM_ADR_D10: s = '{valid: 1'b1, idx: 4'ha};
			`TCPWM_ADR_D11: s = '{valid: 1'b1, idx: 4'hb};
			default: s = '{valid: 1'b0, idx: 4'h0};
		endcase
		return s;
	endfunction
endpackage
`default_nettype wire

// ---- tcpwm_top.sv ----
// Twelve channel 8-bit pulse width modulator with its register file
//
// Operation
// - Twelve independent channels, 8-bit duty each
// - Counter wraps after 255, or 253 selected
// - Counter advances every clock outside low power, rate clock/modulo
// - One counter shared by every channel compare
// - Pin low while duty exceeds counter
// - Duty FEh or FFh stays low in 254
// - New duty value applies without period wait
// - Open drain; idle float or port pull-up
// - Low enable bit x gates channel x
// - High enable bits gate channels 8 to 11
// - Duty registers write only, reset zero
// - Enable registers read/write, reset zero
// - Low power freezes counter, pins idle
// - Control register write only, bit0 modulo
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_cfg.svh"
module tcpwm_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire tcpwm_pkg::tcpwm_sfr_s sfr,
	input wire logic low_power,
	input wire logic [3:0] port_one_latch,
	output logic [7:0] sfr_rdata,
	output logic [11:0] pin_out,
	output logic [11:0] pin_oe,
	output logic [7:0] counter_value
);
	import tcpwm_pkg::*;

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0] enable_reg_low_q;
	logic [3:0] enable_reg_high_q;
	logic modulo_select_q;
	logic [7:0] duty_compare_channel_q [`TCPWM_NCH];
	logic [7:0] sfr_rdata_q;
	logic [11:0] pin_out_q;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	tcpwm_sel_s duty_sel;
	logic wr_enl;
	logic wr_enh;
	logic wr_ctl;
	logic wr_duty;
	logic hit_enl;
	logic hit_enh;
	logic [7:0] rd_mux;

	assign duty_sel = tcpwm_duty_sel(sfr.addr);
	assign hit_enl = sfr.addr == `TCPWM_ADR_ENL;
	assign hit_enh = sfr.addr == `TCPWM_ADR_ENH;
	assign wr_enl = sfr.wr && hit_enl;
	assign wr_enh = sfr.wr && hit_enh;
	assign wr_ctl = sfr.wr && (sfr.addr == `TCPWM_ADR_CTL);
	assign wr_duty = sfr.wr && duty_sel.valid;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			enable_reg_low_q <= `TCPWM_RST_REG;
		end else if (wr_enl) begin
			enable_reg_low_q <= sfr.wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			enable_reg_high_q <= 4'h0;
		end else if (wr_enh) begin
			enable_reg_high_q <= sfr.wdata[3:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			modulo_select_q <= 1'b0;
		end else if (wr_ctl) begin
			modulo_select_q <= sfr.wdata[`TCPWM_MODSEL_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < `TCPWM_NCH; i++) begin
			if (rst) begin
				duty_compare_channel_q[i] <= `TCPWM_RST_REG;
			end else if (wr_duty && duty_sel.idx == 4'(i)) begin
				duty_compare_channel_q[i] <= sfr.wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Write-only and unmapped addresses answer zero; the read value
	// is held until the next read so the core may sample it late.
	assign rd_mux = hit_enl ? enable_reg_low_q :
		hit_enh ? {4'h0, enable_reg_high_q} : `TCPWM_RST_REG;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sfr_rdata_q <= `TCPWM_RST_REG;
		end else if (sfr.rd) begin
			sfr_rdata_q <= rd_mux;
		end
	end

	assign sfr_rdata = sfr_rdata_q;

	// ------------------------------------------------------------
	// Shared counter
	// ------------------------------------------------------------
	logic [7:0] cnt;

	tcpwm_counter u_counter (
		.sys_clk(sys_clk),
		.rst(rst),
		.freeze(low_power),
		.modulo_select(modulo_select_q),
		.count(cnt)
	);

	assign counter_value = cnt;

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	logic [11:0] chan_en;
	logic [11:0] chan_on;
	logic [11:0] chan_latch;

	assign chan_en = {enable_reg_high_q, enable_reg_low_q};
	assign chan_on = chan_en & {12{!low_power}};
	assign chan_latch = {port_one_latch, 8'h00};

	for (genvar i = 0; i < `TCPWM_NCH; i++) begin : g_chan
		tcpwm_chan #(
			.PORT_PIN(i >= `TCPWM_NLOW)
		) u_chan (
			.sys_clk(sys_clk),
			.rst(rst),
			.count(cnt),
			.duty(duty_compare_channel_q[i]),
			.enable(chan_en[i]),
			.freeze(low_power),
			.latch_bit(chan_latch[i]),
			.pin_oe(pin_oe[i])
		);
	end

	// Open drain: the pin value is only ever a low, the enable decides
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_out_q <= 12'h000;
		end else begin
			pin_out_q <= 12'h000;
		end
	end

	assign pin_out = pin_out_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Worked out apart from the counter so its top is checked as well
	logic [7:0] top_now;
	assign top_now = modulo_select_q ? `TCPWM_TOP_254 : `TCPWM_TOP_256;

	// ------------------------------------------------------------
	// Counter checks
	// ------------------------------------------------------------
	a_wrap_full: assert property (
		(!low_power && !modulo_select_q && cnt == `TCPWM_TOP_256)
		|=> cnt == 8'h00)
		else $error("Counter did not wrap after 255");

	a_wrap_short: assert property (
		(!low_power && modulo_select_q && cnt == `TCPWM_TOP_254)
		|=> cnt == 8'h00)
		else $error("Counter did not wrap after 253");

	a_short_range: assert property (
		(!low_power && modulo_select_q)
		|=> cnt <= `TCPWM_TOP_254)
		else $error("Counter passed 253 in the short mode");

	// A switch to the short mode may leave the count above its top
	a_over_wrap: assert property (
		(!low_power && cnt > top_now)
		|=> cnt == 8'h00)
		else $error("Count above top did not wrap");

	a_cnt_step: assert property (
		(!low_power && cnt < top_now)
		|=> cnt == $past(cnt) + 8'h01)
		else $error("Counter did not advance by one");

	a_cnt_freeze: assert property (
		low_power |=> cnt == $past(cnt))
		else $error("Counter moved in low power");

	a_cnt_reset: assert property (
		$past(rst) |-> cnt == 8'h00
		##1 cnt == ($past(low_power) ? 8'h00 : 8'h01))
		else $error("Counter did not start from zero");

	// ------------------------------------------------------------
	// Register checks
	// ------------------------------------------------------------
	a_reg_reset: assert property (
		$past(rst) |-> enable_reg_low_q == 8'h00
		&& enable_reg_high_q == 4'h0 && !modulo_select_q)
		else $error("Control registers not cleared by reset");

	a_pins_reset: assert property (
		$past(rst) |-> pin_oe == 12'h000 && pin_out == 12'h000
		&& sfr_rdata == 8'h00)
		else $error("Outputs not cleared by reset");

	a_enl_write: assert property (
		wr_enl |=> enable_reg_low_q == $past(sfr.wdata))
		else $error("Low enable write lost");

	a_enh_write: assert property (
		wr_enh |=> enable_reg_high_q == $past(sfr.wdata[3:0]))
		else $error("High enable write lost");

	a_mod_write: assert property (
		wr_ctl
		|=> modulo_select_q == $past(sfr.wdata[`TCPWM_MODSEL_BIT]))
		else $error("Modulo select write lost");

	a_read_low: assert property (
		(sfr.rd && hit_enl)
		|=> sfr_rdata == $past(enable_reg_low_q))
		else $error("Low enable read back wrong");

	a_read_high: assert property (
		(sfr.rd && hit_enh)
		|=> sfr_rdata == {4'h0, $past(enable_reg_high_q)})
		else $error("High enable read back wrong");

	a_read_wo: assert property (
		(sfr.rd && (duty_sel.valid || sfr.addr == `TCPWM_ADR_CTL))
		|=> sfr_rdata == 8'h00)
		else $error("Write-only register read non-zero");

	a_read_other: assert property (
		(sfr.rd && !hit_enl && !hit_enh)
		|=> sfr_rdata == 8'h00)
		else $error("Unreadable address read non-zero");

	// The core may take read data late, so it must not drift
	a_read_hold: assert property (
		!sfr.rd |=> sfr_rdata == $past(sfr_rdata))
		else $error("Read data changed without a read");

	// ------------------------------------------------------------
	// Pin checks
	// ------------------------------------------------------------
	a_idle_float: assert property (
		low_power |=> pin_oe[7:0] == 8'h00)
		else $error("Low channel driven in low power");

	a_port_latch: assert property (
		low_power |=> pin_oe[11:8] == ~$past(port_one_latch))
		else $error("Port pin not following latch in low power");

	a_full_low: assert property (
		(chan_on[1] && modulo_select_q && cnt <= `TCPWM_TOP_254
		&& duty_compare_channel_q[1] >= `TCPWM_UNREACH_254)
		|=> pin_oe[1])
		else $error("Unreachable duty released the pin");

	// The pin lags the compare by one clock as the output is registered
	a_write_now: assert property (
		(wr_duty && duty_sel.idx == 4'h0) ##1 chan_on[0]
		|=> pin_oe[0] == ($past(sfr.wdata, 2) > $past(cnt)))
		else $error("New duty value not applied at once");

	a_pin_value: assert property (
		pin_out == 12'h000)
		else $error("Open-drain pin driven high");

	// ------------------------------------------------------------
	// Per-channel checks
	// ------------------------------------------------------------
	for (genvar i = 0; i < `TCPWM_NCH; i++) begin : g_chk
		a_drive_low: assert property (
			(chan_on[i] && duty_compare_channel_q[i] > cnt)
			|=> pin_oe[i])
			else $error("Channel not pulled low above count");

		a_release: assert property (
			(chan_on[i] && duty_compare_channel_q[i] <= cnt)
			|=> !pin_oe[i])
			else $error("Channel held low at or below count");

		a_zero_duty: assert property (
			(chan_on[i] && duty_compare_channel_q[i] == 8'h00)
			|=> !pin_oe[i])
			else $error("Zero duty pulled the pin low");

		a_never_reach: assert property (
			(chan_on[i] && modulo_select_q
			&& cnt <= `TCPWM_TOP_254
			&& duty_compare_channel_q[i] >= `TCPWM_UNREACH_254)
			|=> pin_oe[i])
			else $error("Unreachable duty released a pin");

		a_duty_write: assert property (
			(wr_duty && duty_sel.idx == 4'(i))
			|=> duty_compare_channel_q[i] == $past(sfr.wdata))
			else $error("Duty write lost");

		a_duty_reset: assert property (
			$past(rst) |-> duty_compare_channel_q[i] == 8'h00)
			else $error("Duty register not cleared by reset");
	end

	for (genvar i = 0; i < `TCPWM_NLOW; i++) begin : g_low
		a_off_float: assert property (
			!chan_en[i] |=> !pin_oe[i])
			else $error("Disabled low channel not floating");
	end

	for (genvar i = 0; i < `TCPWM_NHIGH; i++) begin : g_high
		a_off_port: assert property (
			!chan_en[i + `TCPWM_NLOW]
			|=> pin_oe[i + `TCPWM_NLOW] == !$past(port_one_latch[i]))
			else $error("Disabled port channel not following latch");
	end

endmodule // tcpwm_top
`default_nettype wire
